// file: rid_pkg.sv
package rid_pkg;
  // =====================================================
  // Instruction encoding
  localparam int OPC_W = 6;
  localparam logic [5:0] OPC_RLNC = 6'h11;
  localparam logic [5:0] OPC_RRC = 6'h0C;
  localparam int OPC_MSB = 15;
  localparam int DEST_BIT = 9;
  localparam int ACC_BIT = 8;
  // =====================================================
  // Addressing
  localparam logic [7:0] ILO_LIMIT = 8'h5F;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  // =====================================================
  // Reset values
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [3:0] BSR_RST = 4'h0;

  typedef enum logic [1:0] {
    RID_Q1,
    RID_Q2,
    RID_Q3,
    RID_Q4
  } rid_phase_t;

  typedef struct packed {
    logic carry;
    logic negative;
    logic zero;
  } rid_flags_t;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
  } rid_ram_wr_t;
endpackage

// file: rid_core.sv
// Operation
// - Left rotate shifts file register one bit left, carry untouched.
// - Right rotate shifts through carry as ninth bit.
// - Destination bit clear: result to working register, file unchanged.
// - Destination bit set: result written back to file register.
// - Access bit clear: operand from quick-access bank.
// - Access bit set: bank select register picks the RAM bank.
// - Extended set, access clear, address up to 95: indexed literal offset.
// - One word, one cycle of four phases: decode, read, process, write.
`timescale 1ns/10ps
module rid_core (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic ext_set_en,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] index_base,
  input wire logic [7:0] ram_rdata,
  output logic [11:0] ram_raddr,
  output rid_pkg::rid_ram_wr_t ram_wr,
  output logic [7:0] w_reg,
  output rid_pkg::rid_flags_t flags,
  output logic busy
);

  rid_pkg::rid_phase_t phase_q;
  logic [15:0] instr_q;
  logic active_q;
  logic [11:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] res_q;
  logic carry_out_q;
  logic is_rot;
  logic [11:0] ea_d;

  // =====================================================
  // Decode helpers
  function automatic logic is_rotate(input logic [15:0] op);
    is_rotate = (op[15:10] == rid_pkg::OPC_RLNC) || (op[15:10] == rid_pkg::OPC_RRC);
  endfunction

  assign is_rot = is_rotate(instr);
  assign busy = active_q;

  // =====================================================
  // Effective address
  always_comb begin
    logic [7:0] f;
    f = instr_q[7:0];
    if (!instr_q[rid_pkg::ACC_BIT]) begin
      if (ext_set_en && f <= rid_pkg::ILO_LIMIT) begin
        ea_d = index_base + {4'h0, f};
      end else if (f < rid_pkg::ACC_SPLIT) begin
        ea_d = {4'h0, f};
      end else begin
        ea_d = {rid_pkg::ACC_HI_BANK, f};
      end
    end else begin
      ea_d = {bank_select_register, f};
    end
  end

  // =====================================================
  // Phase sequencer
  // four-phase cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phase_q <= RID_Q1_RST;
      active_q <= 1'b0;
      instr_q <= 16'h0000;
    end else begin
      case (phase_q)
        rid_pkg::RID_Q1: begin
          if (instr_valid && is_rot) begin
            instr_q <= instr;
            active_q <= 1'b1;
            phase_q <= rid_pkg::RID_Q2;
          end
        end
        rid_pkg::RID_Q2: phase_q <= rid_pkg::RID_Q3;
        rid_pkg::RID_Q3: phase_q <= rid_pkg::RID_Q4;
        rid_pkg::RID_Q4: begin
          phase_q <= rid_pkg::RID_Q1;
          active_q <= 1'b0;
        end
        default: phase_q <= rid_pkg::RID_Q1;
      endcase
    end
  end

  localparam rid_pkg::rid_phase_t RID_Q1_RST = rid_pkg::RID_Q1;

  assign ram_raddr = addr_q;

  // =====================================================
  // Read and process
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      addr_q <= 12'h000;
      data_q <= 8'h00;
      res_q <= 8'h00;
      carry_out_q <= 1'b0;
    end else begin
      if (phase_q == rid_pkg::RID_Q2) begin
        addr_q <= ea_d;
      end
      if (phase_q == rid_pkg::RID_Q3) begin
        data_q <= ram_rdata;
        if (instr_q[15:10] == rid_pkg::OPC_RLNC) begin
          res_q <= {ram_rdata[6:0], ram_rdata[7]};
          carry_out_q <= flags.carry;
        end else begin
          res_q <= {flags.carry, ram_rdata[7:1]};
          carry_out_q <= ram_rdata[0];
        end
      end
    end
  end

  // =====================================================
  // Write destination and flags
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      w_reg <= rid_pkg::W_RST;
      flags <= '0;
      ram_wr <= '0;
    end else begin
      ram_wr.we <= 1'b0;
      if (phase_q == rid_pkg::RID_Q4) begin
        flags.negative <= res_q[7];
        flags.zero <= (res_q == 8'h00);
        flags.carry <= carry_out_q;
        if (instr_q[rid_pkg::DEST_BIT]) begin
          ram_wr.we <= 1'b1;
          ram_wr.addr <= addr_q;
          ram_wr.wdata <= res_q;
        end else begin
          w_reg <= res_q;
        end
      end
    end
  end

endmodule

// file: rid_chk.sv
`timescale 1ns/10ps
module rid_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic ext_set_en,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] index_base,
  input wire logic [11:0] ram_raddr,
  input wire rid_pkg::rid_ram_wr_t ram_wr,
  input wire rid_pkg::rid_flags_t flags,
  input wire logic busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // =====
  // Accept decode
  wire [7:0] f = instr[7:0];
  wire [5:0] op = instr[15:10];
  wire acc = !busy && instr_valid && (op == rid_pkg::OPC_RLNC || op == rid_pkg::OPC_RRC);
  wire qa = acc && !instr[8];
  AST_BUSY: assert property (acc |=> busy ##[2:4] !busy) else $error("span");
  AST_WB: assert property (acc && instr[9] |-> ##[2:5] ram_wr.we) else $error("no wr");
  AST_NOWB: assert property (acc && !instr[9] |=> !ram_wr.we [*5]) else $error("wr");
  AST_LC: assert property (
    acc && op == rid_pkg::OPC_RLNC |=> $stable(flags.carry) [*4]) else $error("carry");
  AST_BANK: assert property (
    acc && instr[8] |-> ##[1:4] ram_raddr == {bank_select_register, f}) else $error("bank");
  AST_QA: assert property (
    qa && !ext_set_en |-> ##[1:4] ram_raddr == {(f < 8'h60) ? 4'h0 : 4'hF, f}) else $error("qa");
  AST_ILO: assert property (
    qa && ext_set_en && f <= 8'h5F |-> ##[1:4] ram_raddr == index_base + 12'(f)) else $error("ilo");
  AST_NZ: assert property (
    ram_wr.we |-> {flags.negative, flags.zero} == {ram_wr.wdata[7], ram_wr.wdata == 8'h00})
    else $error("nz");
  cover property (acc && instr[9]);
  cover property (qa && ext_set_en);
  cover property (ram_wr.we && flags.zero);
endmodule
bind rid_core rid_chk u_chk (.*);

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_sys, rst_b, instr_valid, ext_set_en, busy, c, wr;
  logic [15:0] instr;
  logic [3:0] bank_select_register;
  logic [11:0] index_base, ram_raddr;
  logic [7:0] ram_rdata, w_reg, r;
  rid_pkg::rid_ram_wr_t ram_wr;
  rid_pkg::rid_flags_t flags;
  int failures, n_tests;
  rid_core uut (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // =====
  // Mode bits: left, dest, access, extended
  task automatic run(input logic [3:0] m, input logic [7:0] f, input logic [7:0] v);
    r = m[3] ? {v[6:0], v[7]} : {c, v[7:1]};
    c = m[3] ? c : v[0];
    wr = 1'b0;
    instr = {m[3] ? rid_pkg::OPC_RLNC : rid_pkg::OPC_RRC, m[2:1], f};
    {ext_set_en, ram_rdata, instr_valid} = {m[0], v, 1'b1};
    repeat (6) begin
      @(negedge clk_sys);
      instr_valid = 1'b0;
      if (ram_wr.we === 1'b1) chk(ram_wr.wdata, r);
      wr |= ram_wr.we;
    end
    chk(wr, m[2]);
    if (!m[2]) chk(w_reg, r);
    chk(flags, {c, r[7], r == 8'h00});
    $display("done %h", instr);
  endtask
  initial begin
    {rst_b, instr_valid, ext_set_en, c, instr, ram_rdata} = '0;
    bank_select_register = 4'h3;
    index_base = 12'h100;
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    run(4'hC, 8'h20, 8'hAB);
    run(4'h0, 8'h70, 8'hE6);
    run(4'h2, 8'h10, 8'h01);
    run(4'h6, 8'h10, 8'h00);
    run(4'h9, 8'h5F, 8'h80);
    run(4'hD, 8'h60, 8'h00);
    finish_test();
  end
  initial begin
    #2000;
    failures++;
    finish_test();
  end
endmodule
